// >>> rtl/ebc_defs.svh
// timing counts, field positions and reset values of the bus control block
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

// address decode fields
`define EBC_BANK_HI 31
`define EBC_BANK_LO 27
`define EBC_BANK0_CODE 5'h06
`define EBC_BANK1_CODE 5'h07
`define EBC_HOST_BIT 31
`define EBC_ODD_WORD_BIT 0

// cycles before a sampled acknowledge reflects the current access
`define EBC_ACK_WAIT 3'h3
// cycles after reset release before the boot strap is caught
`define EBC_STRAP_WAIT 2'h3

// reset values
`define EBC_ADDR_RST 32'h0000_0000
`define EBC_DATA_RST 64'h0000_0000_0000_0000
`define EBC_CTL_RST 7'h7f

// positions inside the synchronised control group
`define EBC_CTL_RD 0
`define EBC_CTL_WRL 1
`define EBC_CTL_WRH 2
`define EBC_CTL_ACK 3
`define EBC_CTL_BURST 4
`define EBC_CTL_HBG 5
`define EBC_CTL_BCS 6

`endif

// >>> rtl/ebc_pkg.sv
// types shared by the bus control block
package ebc_pkg;
    typedef logic [31:0] ebc_addr_t;
    typedef logic [63:0] ebc_data_t;
    typedef enum logic [2:0] {
        st_idle,
        st_m_wait,
        st_s_mem,
        st_s_gap,
        st_s_end
    } ebc_state_e;
endpackage

// >>> rtl/ebc_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module ebc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // pins in, synchronised copy out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// >>> rtl/ebc_burst_ctr.sv
// slave-side address counter: loads the first address, then increments
`timescale 1ns/100ps
module ebc_burst_ctr #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_load_addr,
    input wire logic i_inc,
    // current address
    output logic [WIDTH-1:0] o_addr
);
    logic [WIDTH-1:0] next_addr;

    always_comb begin
        next_addr = o_addr;
        if (i_load) begin
            next_addr = i_load_addr;
        end else if (i_inc) begin
            next_addr = o_addr + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_addr <= '0;
        end else begin
            o_addr <= next_addr;
        end
    end
endmodule

// >>> rtl/ebc_top.sv
// external port bus control: master strobes, decode, slave access, strap
//
// Function
// - address bits 31..27 = 00110 asserts bank select zero.
// - address bits 31..27 = 00111 asserts bank select one.
// - address bit 31 set asserts host-space select.
// - selects are registered together with the address bus.
// - master reads (non-SDRAM) assert read strobe together with address.
// - as slave, read strobe is an input requesting internal reads.
// - low write strobe on long word or even word writes and all 32-bit zone writes.
// - high write strobe on long word or odd word writes, 64-bit bus.
// - as slave, both write strobes are inputs marking internal writes.
// - as slave, device holds acknowledge deasserted to add wait states.
// - boot chip select drives during boot accesses.
// - boot chip select pin is sampled at reset as boot mode strap.
// - only the bus master drives address, strobes and boot select; bank and host selects are always driven, high when idle.
// - as slave, address bus is an input for internal accesses.
// - master asserts burst on consecutive addresses; slave counts them.
// - during host burst the slave address increments while burst holds.
// - data bus is driven or received depending on direction.
// - on host grant, address, strobes and boot select float and data drives only for slave reads; bank and host selects drive high.
`timescale 1ns/100ps
`include "ebc_defs.svh"
module ebc_top (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // bus ownership from arbitration
    input wire logic i_bus_master,
    input wire logic i_host_bus_grant_n,
    // master request port
    input wire logic i_req,
    input wire logic i_req_write,
    input wire logic i_req_long,
    input wire logic i_req_zone32,
    input wire logic i_req_burst,
    input wire logic i_req_boot,
    input wire logic [31:0] i_req_addr,
    input wire logic [63:0] i_req_wdata,
    output logic o_req_accept,
    output logic o_req_done,
    output logic [63:0] o_req_rdata,
    // slave internal memory port
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [1:0] o_mem_word_en,
    output logic [31:0] o_mem_addr,
    output logic [63:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [63:0] i_mem_rdata,
    // address and data pins
    input wire logic [31:0] i_ext_address_bus,
    output logic [31:0] o_ext_address_bus,
    output logic o_ext_address_bus_oe,
    input wire logic [63:0] i_ext_data_bus,
    output logic [63:0] o_ext_data_bus,
    output logic o_ext_data_bus_oe,
    // strobe pins
    input wire logic i_read_strobe_n,
    output logic o_read_strobe_n,
    input wire logic i_write_low_strobe_n,
    output logic o_write_low_strobe_n,
    input wire logic i_write_high_strobe_n,
    output logic o_write_high_strobe_n,
    input wire logic i_burst_flag_n,
    output logic o_burst_flag_n,
    output logic o_ctl_oe,
    // acknowledge pin, open drain
    input wire logic i_ack_n,
    output logic o_ack_n,
    output logic o_ack_oe,
    // select pins
    output logic [1:0] o_bank_select_n,
    output logic o_host_space_select_n,
    input wire logic i_boot_chip_select_n,
    output logic o_boot_chip_select_n,
    output logic o_boot_chip_select_oe,
    // strap result
    output logic o_eprom_boot_strap
);
    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    logic [1:0] rst_ff;
    logic rst_n;
    logic [31:0] addr_s;
    logic [63:0] data_s;
    logic [6:0] ctl_s;
    logic rd_s, wrl_s, wrh_s, ack_s, burst_s, hbg_s, bcs_s;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];

    ebc_sync #(.WIDTH(32), .RESET_VALUE(`EBC_ADDR_RST)) u_addr_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_async(i_ext_address_bus),
        .o_sync(addr_s)
    );
    ebc_sync #(.WIDTH(64), .RESET_VALUE(`EBC_DATA_RST)) u_data_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_async(i_ext_data_bus),
        .o_sync(data_s)
    );
    ebc_sync #(.WIDTH(7), .RESET_VALUE(`EBC_CTL_RST)) u_ctl_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_async({i_boot_chip_select_n, i_host_bus_grant_n,
                  i_burst_flag_n, i_ack_n, i_write_high_strobe_n,
                  i_write_low_strobe_n, i_read_strobe_n}),
        .o_sync(ctl_s)
    );
    assign rd_s = ctl_s[`EBC_CTL_RD];
    assign wrl_s = ctl_s[`EBC_CTL_WRL];
    assign wrh_s = ctl_s[`EBC_CTL_WRH];
    assign ack_s = ctl_s[`EBC_CTL_ACK];
    assign burst_s = ctl_s[`EBC_CTL_BURST];
    assign hbg_s = ctl_s[`EBC_CTL_HBG];
    assign bcs_s = ctl_s[`EBC_CTL_BCS];

    // ****************************************
    // boot strap capture
    // ****************************************
    logic [1:0] strap_cnt, next_strap_cnt;
    logic strap_done, next_strap_done;
    logic next_strap;

    always_comb begin
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;
        next_strap = o_eprom_boot_strap;
        if (!strap_done) begin
            if (strap_cnt == `EBC_STRAP_WAIT) begin
                next_strap = bcs_s;
                next_strap_done = 1'b1;
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            o_eprom_boot_strap <= 1'b0;
        end else begin
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
            o_eprom_boot_strap <= next_strap;
        end
    end

    // ****************************************
    // bus sequencer
    // ****************************************
    ebc_pkg::ebc_state_e state, next_state;
    logic [2:0] cnt, next_cnt;
    logic owner;
    logic slv_hit;
    logic m_write, next_m_write;
    logic ctr_load, ctr_inc;
    logic next_req_accept, next_req_done;
    logic [63:0] next_req_rdata;
    logic next_mem_req, next_mem_we;
    logic [1:0] next_mem_word_en;
    logic [63:0] next_mem_wdata;
    logic [31:0] next_addr_o;
    logic next_addr_oe, next_data_oe, next_ctl_oe;
    logic [63:0] next_data_o;
    logic next_rd_n, next_wrl_n, next_wrh_n, next_burst_n;
    logic next_ack_n, next_ack_oe;
    logic [1:0] next_bank_n;
    logic next_host_n, next_bcs_n, next_bcs_oe;

    // host grant pulls even the arbitrated master off the pins
    assign owner = i_bus_master && hbg_s && strap_done;
    assign slv_hit = !rd_s || !wrl_s || !wrh_s;

    ebc_burst_ctr #(.WIDTH(32)) u_burst_ctr (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_load(ctr_load),
        .i_load_addr(addr_s),
        .i_inc(ctr_inc),
        .o_addr(o_mem_addr)
    );

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_m_write = m_write;
        ctr_load = 1'b0;
        ctr_inc = 1'b0;
        next_req_accept = 1'b0;
        next_req_done = 1'b0;
        next_req_rdata = o_req_rdata;
        next_mem_req = 1'b0;
        next_mem_we = o_mem_we;
        next_mem_word_en = o_mem_word_en;
        next_mem_wdata = o_mem_wdata;
        next_addr_o = o_ext_address_bus;
        next_addr_oe = o_ext_address_bus_oe;
        next_data_o = o_ext_data_bus;
        next_data_oe = o_ext_data_bus_oe;
        next_ctl_oe = o_ctl_oe;
        next_rd_n = o_read_strobe_n;
        next_wrl_n = o_write_low_strobe_n;
        next_wrh_n = o_write_high_strobe_n;
        next_burst_n = o_burst_flag_n;
        next_ack_n = o_ack_n;
        next_ack_oe = o_ack_oe;
        next_bank_n = o_bank_select_n;
        next_host_n = o_host_space_select_n;
        next_bcs_n = o_boot_chip_select_n;
        next_bcs_oe = o_boot_chip_select_oe;
        unique case (state)
            ebc_pkg::st_idle: begin
                next_rd_n = 1'b1;
                next_wrl_n = 1'b1;
                next_wrh_n = 1'b1;
                next_burst_n = 1'b1;
                next_bank_n = 2'h3;
                next_host_n = 1'b1;
                next_bcs_n = 1'b1;
                next_data_oe = 1'b0;
                next_ack_oe = 1'b0;
                next_ack_n = 1'b1;
                next_addr_oe = owner;
                next_ctl_oe = owner;
                next_bcs_oe = owner;
                if (owner && i_req) begin
                    next_req_accept = 1'b1;
                    next_m_write = i_req_write;
                    next_addr_o = i_req_addr;
                    // decode registered with the address
                    next_bank_n[0] = !(i_req_addr[`EBC_BANK_HI:`EBC_BANK_LO]
                                       == `EBC_BANK0_CODE);
                    next_bank_n[1] = !(i_req_addr[`EBC_BANK_HI:`EBC_BANK_LO]
                                       == `EBC_BANK1_CODE);
                    next_host_n = !i_req_addr[`EBC_HOST_BIT];
                    next_bcs_n = !i_req_boot;
                    next_burst_n = !i_req_burst;
                    next_rd_n = i_req_write;
                    next_wrl_n = !(i_req_write && (i_req_zone32
                                   || i_req_long
                                   || !i_req_addr[`EBC_ODD_WORD_BIT]));
                    next_wrh_n = !(i_req_write && !i_req_zone32
                                   && (i_req_long
                                   || i_req_addr[`EBC_ODD_WORD_BIT]));
                    next_data_o = i_req_wdata;
                    next_data_oe = i_req_write;
                    next_cnt = `EBC_ACK_WAIT;
                    next_state = ebc_pkg::st_m_wait;
                end else if (!owner && slv_hit) begin
                    ctr_load = 1'b1;
                    next_mem_req = 1'b1;
                    next_mem_we = rd_s;
                    next_mem_word_en = {!wrh_s, !wrl_s};
                    next_mem_wdata = data_s;
                    next_ack_oe = 1'b1;
                    next_ack_n = 1'b0;
                    next_state = ebc_pkg::st_s_mem;
                end
            end
            ebc_pkg::st_m_wait: begin
                if (cnt != 3'h0) begin
                    next_cnt = cnt - 3'h1;
                end else if (ack_s) begin
                    // access stretched while acknowledge low
                    next_req_done = 1'b1;
                    if (!m_write) begin
                        next_req_rdata = data_s;
                    end
                    next_rd_n = 1'b1;
                    next_wrl_n = 1'b1;
                    next_wrh_n = 1'b1;
                    next_data_oe = 1'b0;
                    next_state = ebc_pkg::st_idle;
                end
            end
            ebc_pkg::st_s_mem: begin
                if (i_mem_ack) begin
                    if (!o_mem_we) begin
                        next_data_o = i_mem_rdata;
                        next_data_oe = 1'b1;
                    end
                    next_ack_oe = 1'b0;
                    next_ack_n = 1'b1;
                    next_cnt = `EBC_ACK_WAIT;
                    next_state = ebc_pkg::st_s_gap;
                end
            end
            ebc_pkg::st_s_gap: begin
                if (cnt != 3'h0) begin
                    next_cnt = cnt - 3'h1;
                end else if (!burst_s && slv_hit && !owner) begin
                    ctr_inc = 1'b1;
                    next_mem_req = 1'b1;
                    next_mem_wdata = data_s;
                    next_data_oe = 1'b0;
                    next_ack_oe = 1'b1;
                    next_ack_n = 1'b0;
                    next_state = ebc_pkg::st_s_mem;
                end else begin
                    next_state = ebc_pkg::st_s_end;
                end
            end
            ebc_pkg::st_s_end: begin
                // one access per strobe outside a burst
                if (!slv_hit) begin
                    next_data_oe = 1'b0;
                    next_state = ebc_pkg::st_idle;
                end
            end
            default: begin
                next_state = ebc_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ebc_pkg::st_idle;
            cnt <= 3'h0;
            m_write <= 1'b0;
            o_req_accept <= 1'b0;
            o_req_done <= 1'b0;
            o_req_rdata <= `EBC_DATA_RST;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_word_en <= 2'h0;
            o_mem_wdata <= `EBC_DATA_RST;
            o_ext_address_bus <= `EBC_ADDR_RST;
            o_ext_address_bus_oe <= 1'b0;
            o_ext_data_bus <= `EBC_DATA_RST;
            o_ext_data_bus_oe <= 1'b0;
            o_ctl_oe <= 1'b0;
            o_read_strobe_n <= 1'b1;
            o_write_low_strobe_n <= 1'b1;
            o_write_high_strobe_n <= 1'b1;
            o_burst_flag_n <= 1'b1;
            o_ack_n <= 1'b1;
            o_ack_oe <= 1'b0;
            o_bank_select_n <= 2'h3;
            o_host_space_select_n <= 1'b1;
            o_boot_chip_select_n <= 1'b1;
            o_boot_chip_select_oe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            m_write <= next_m_write;
            o_req_accept <= next_req_accept;
            o_req_done <= next_req_done;
            o_req_rdata <= next_req_rdata;
            o_mem_req <= next_mem_req;
            o_mem_we <= next_mem_we;
            o_mem_word_en <= next_mem_word_en;
            o_mem_wdata <= next_mem_wdata;
            o_ext_address_bus <= next_addr_o;
            o_ext_address_bus_oe <= next_addr_oe;
            o_ext_data_bus <= next_data_o;
            o_ext_data_bus_oe <= next_data_oe;
            o_ctl_oe <= next_ctl_oe;
            o_read_strobe_n <= next_rd_n;
            o_write_low_strobe_n <= next_wrl_n;
            o_write_high_strobe_n <= next_wrh_n;
            o_burst_flag_n <= next_burst_n;
            o_ack_n <= next_ack_n;
            o_ack_oe <= next_ack_oe;
            o_bank_select_n <= next_bank_n;
            o_host_space_select_n <= next_host_n;
            o_boot_chip_select_n <= next_bcs_n;
            o_boot_chip_select_oe <= next_bcs_oe;
        end
    end
endmodule

// >>> tb/ebc_chk.sv
// assertions on the bus control pins
`timescale 1ns/100ps
module ebc_chk (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // watched ports
    input wire logic i_bus_master,
    input wire logic o_req_accept,
    input wire logic o_req_done,
    input wire logic o_mem_req,
    input wire logic [31:0] o_ext_address_bus,
    input wire logic o_ext_data_bus_oe,
    input wire logic o_read_strobe_n,
    input wire logic o_write_low_strobe_n,
    input wire logic o_write_high_strobe_n,
    input wire logic o_ctl_oe,
    input wire logic o_ack_n,
    input wire logic o_ack_oe,
    input wire logic [1:0] o_bank_select_n,
    input wire logic o_host_space_select_n,
    input wire logic o_boot_chip_select_oe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);
    property p_bank0;
        o_req_accept |->
            o_bank_select_n[0] == (o_ext_address_bus[31:27] != 5'h06);
    endproperty
    a_bank0: assert property (p_bank0) else $error("bank zero select wrong");
    property p_bank1;
        o_req_accept |->
            o_bank_select_n[1] == (o_ext_address_bus[31:27] != 5'h07);
    endproperty
    a_bank1: assert property (p_bank1) else $error("bank one select wrong");
    property p_host;
        o_req_accept |-> o_host_space_select_n == !o_ext_address_bus[31];
    endproperty
    a_host: assert property (p_host) else $error("host select wrong");
    property p_same;
        o_ctl_oe && $changed(o_ext_address_bus) |->
            o_host_space_select_n == !o_ext_address_bus[31];
    endproperty
    a_same: assert property (p_same) else $error("select lags address");
    property p_kind;
        o_req_accept |->
            o_read_strobe_n ^ (o_write_low_strobe_n & o_write_high_strobe_n);
    endproperty
    a_kind: assert property (p_kind) else $error("strobe kind wrong");
    property p_wait;
        o_req_accept |-> !o_req_done [*4];
    endproperty
    a_wait: assert property (p_wait) else $error("access ended early");
    property p_done;
        o_req_accept |-> ##[4:60] o_req_done;
    endproperty
    a_done: assert property (p_done) else $error("access never ended");
    property p_slack;
        o_mem_req |-> o_ack_oe && !o_ack_n;
    endproperty
    a_slack: assert property (p_slack) else $error("no slave wait state");
    property p_owner;
        $rose(o_ctl_oe) |-> $past(i_bus_master);
    endproperty
    a_owner: assert property (p_owner) else $error("drove bus unowned");
    property p_boot;
        o_boot_chip_select_oe |-> o_ctl_oe;
    endproperty
    a_boot: assert property (p_boot) else $error("boot select driven idle");
    property p_dir;
        o_ext_data_bus_oe |-> !(o_ctl_oe && !o_read_strobe_n);
    endproperty
    a_dir: assert property (p_dir) else $error("data driven on read");
    property p_odrain;
        o_ack_oe |-> !o_ack_n;
    endproperty
    a_odrain: assert property (p_odrain) else $error("ack driven high");
endmodule
bind ebc_top ebc_chk ebc_chk_i (.*);

// >>> tb/ebc_partner.sv
// far-side slave: wait states on acknowledge, read data
`timescale 1ns/100ps
module ebc_partner (
    // clock
    input wire logic i_sys_clk,
    // wires as seen by the slave
    input wire logic i_en,
    input wire logic [31:0] i_addr,
    input wire logic i_rd_n,
    input wire logic i_wrl_n,
    input wire logic i_wrh_n,
    input wire logic [3:0] i_wait,
    // acknowledge pull-down and read data
    output logic o_ack_low,
    output logic [63:0] o_rdata,
    output logic o_rdata_oe
);
    logic [3:0] cnt = 4'h0;
    logic act;
    assign act = i_en && !(i_rd_n && i_wrl_n && i_wrh_n);
    always @(posedge i_sys_clk) begin
        cnt <= act ? cnt + 4'h1 : 4'h0;
        o_ack_low <= act && (cnt < i_wait);
        o_rdata_oe <= act && !i_rd_n;
        o_rdata <= {~i_addr, i_addr};
    end
endmodule

// >>> tb/test_ext_bus_control_decode.sv
// bench for the bus control block
`timescale 1ns/100ps
module test_ext_bus_control_decode;
    logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_bus_master = 1'b1;
    logic i_host_bus_grant_n = 1'b1, i_req = 1'b0, i_req_write = 1'b0;
    logic i_req_long = 1'b0, i_req_zone32 = 1'b0, i_req_burst = 1'b0;
    logic i_req_boot = 1'b0, i_mem_ack = 1'b0;
    logic [31:0] i_req_addr = 32'h0000_0000, h_addr = 32'h0000_0000;
    logic [63:0] i_req_wdata = '0, i_mem_rdata = '0, h_data = '0;
    logic h_oe = 1'b0, h_rd_n = 1'b1, h_wrl_n = 1'b1, h_wrh_n = 1'b1;
    logic h_burst_flag_n_n = 1'b1, strap = 1'b0, p_ack, p_oe;
    logic [3:0] p_wait = 4'h0;
    logic [63:0] p_data, i_ext_data_bus, o_ext_data_bus, o_req_rdata;
    logic [63:0] o_mem_wdata;
    logic [31:0] i_ext_address_bus, o_ext_address_bus, o_mem_addr;
    logic i_read_strobe_n, i_write_low_strobe_n, i_write_high_strobe_n;
    logic i_burst_flag_n, i_ack_n, i_boot_chip_select_n;
    logic o_req_accept, o_req_done, o_mem_req, o_mem_we, o_ctl_oe;
    logic o_ext_address_bus_oe, o_ext_data_bus_oe, o_read_strobe_n;
    logic o_write_low_strobe_n, o_write_high_strobe_n, o_burst_flag_n;
    logic o_ack_n, o_ack_oe, o_host_space_select_n, o_boot_chip_select_n;
    logic o_boot_chip_select_oe, o_eprom_boot_strap;
    logic [1:0] o_mem_word_en, o_bank_select_n;
    logic [4:0] codes [4] = '{5'h06, 5'h07, 5'h10, 5'h01};
    logic [2:0] kinds [4] = '{3'h0, 3'h4, 3'h6, 3'h5};
    int fails = 0, compares = 0, seed = 65246, i;
    logic [31:0] r, r2;
    // wire levels from every driver, pull-ups otherwise
    assign i_ext_address_bus = o_ext_address_bus_oe ? o_ext_address_bus :
                               h_oe ? h_addr : '1;
    assign i_ext_data_bus = o_ext_data_bus_oe ? o_ext_data_bus :
                            p_oe === 1'b1 ? p_data :
                            (h_oe && h_rd_n) ? h_data : '1;
    assign i_read_strobe_n = o_ctl_oe ? o_read_strobe_n : h_rd_n;
    assign i_write_low_strobe_n = o_ctl_oe ? o_write_low_strobe_n : h_wrl_n;
    assign i_write_high_strobe_n = o_ctl_oe ? o_write_high_strobe_n : h_wrh_n;
    assign i_burst_flag_n = o_ctl_oe ? o_burst_flag_n : h_burst_flag_n_n;
    assign i_ack_n = !((o_ack_oe && !o_ack_n) || p_ack === 1'b1);
    assign i_boot_chip_select_n = o_boot_chip_select_oe ?
                                  o_boot_chip_select_n : strap;
    ebc_top ebc_top_i (.*);
    ebc_partner ebc_partner_i (.i_sys_clk, .i_en(o_ctl_oe),
        .i_addr(i_ext_address_bus), .i_rd_n(i_read_strobe_n),
        .i_wrl_n(i_write_low_strobe_n), .i_wrh_n(i_write_high_strobe_n),
        .i_wait(p_wait), .o_ack_low(p_ack), .o_rdata(p_data),
        .o_rdata_oe(p_oe));
    function automatic logic [63:0] mem_f(input logic [31:0] a);
        return {a ^ 32'h5a5a_5a5a, ~a};
    endfunction
    // internal memory answers one cycle after each request
    always @(posedge i_sys_clk) begin
        i_mem_ack <= o_mem_req;
        i_mem_rdata <= mem_f(o_mem_addr);
    end
    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic timeout_if(input logic ok);
        if (ok !== 1'b1) begin
            fails++;
            print_verdict;
        end
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        i_arst_n = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        check({o_ctl_oe, o_ext_data_bus_oe, o_ack_oe, o_read_strobe_n,
               o_bank_select_n}, 6'h07);
        i_arst_n = 1'b1;
        repeat (12) @(negedge i_sys_clk);
        check(o_eprom_boot_strap, s);
        $display("test reset done");
    endtask
    task automatic m_access(input logic [4:0] k, input logic [31:0] a,
                            input logic [63:0] d, input logic [3:0] w);
        logic wl, wh;
        int n;
        wl = k[4] & (k[2] | k[3] | !a[0]);
        wh = k[4] & !k[2] & (k[3] | a[0]);
        {i_req_write, i_req_long, i_req_zone32, i_req_burst, i_req_boot} = k;
        i_req_addr = a;
        i_req_wdata = d;
        p_wait = w;
        i_req = 1'b1;
        for (n = 0; n < 40 && o_req_accept !== 1'b1; n++)
            @(negedge i_sys_clk);
        timeout_if(o_req_accept);
        i_req = 1'b0;
        check(o_ext_address_bus, a);
        check(o_bank_select_n,
              {a[31:27] != 5'h07, a[31:27] != 5'h06});
        check(o_host_space_select_n, !a[31]);
        check({o_read_strobe_n, o_write_low_strobe_n, o_write_high_strobe_n},
              {k[4], !wl, !wh});
        check({o_burst_flag_n, o_boot_chip_select_n, o_ctl_oe},
              {!k[1], !k[0], 1'b1});
        if (k[4])
            check({o_ext_data_bus_oe, o_ext_data_bus}, {1'b1, d});
        for (n = 0; n < 80 && o_req_done !== 1'b1; n++)
            @(negedge i_sys_clk);
        timeout_if(o_req_done);
        if (!k[4])
            check(o_req_rdata, {~a, a});
        repeat (2) @(negedge i_sys_clk);
    endtask
    task automatic s_access(input logic rd, input logic [1:0] we,
                            input int beats, input logic [31:0] a);
        int b, n;
        h_oe = 1'b1;
        h_addr = a;
        h_rd_n = !rd;
        {h_wrh_n, h_wrl_n} = ~we;
        h_burst_flag_n_n = (beats == 1);
        for (b = 0; b < beats; b++) begin
            h_data = mem_f(~(a + b));
            // step past the pulse of the beat before
            @(negedge i_sys_clk);
            for (n = 0; n < 60 && o_mem_req !== 1'b1; n++)
                @(negedge i_sys_clk);
            timeout_if(o_mem_req);
            check({o_mem_addr, o_mem_we, o_mem_word_en, o_ack_oe, o_ack_n},
                  {a + b, !rd, we, 2'h2});
            if (!rd)
                check(o_mem_wdata, mem_f(~(a + b)));
            if (b == beats - 1)
                h_burst_flag_n_n = 1'b1;
            for (n = 0; n < 20 && o_ext_data_bus_oe !== rd; n++)
                @(negedge i_sys_clk);
            timeout_if(o_ext_data_bus_oe === rd);
            if (rd)
                check(o_ext_data_bus, mem_f(a + b));
        end
        n = 0;
        repeat (16) begin
            @(negedge i_sys_clk);
            n += (o_mem_req === 1'b1);
        end
        check(n, 0);
        {h_rd_n, h_wrl_n, h_wrh_n, h_oe} = 4'he;
        repeat (6) @(negedge i_sys_clk);
    endtask
    initial begin
        do_reset(1'b0);
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            m_access({kinds[(i / 4) % 4], r2[1:0]}, {codes[i % 4], r[26:0]},
                     {r2, r}, {1'b0, r2[4:2]});
        end
        $display("test master done");
        i_host_bus_grant_n = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        i_req = 1'b1;
        repeat (20) begin
            @(negedge i_sys_clk);
            check({o_req_accept, o_ctl_oe, o_ext_address_bus_oe,
                   o_ext_data_bus_oe}, 4'h0);
        end
        i_req = 1'b0;
        i_bus_master = 1'b0;
        $display("test release done");
        s_access(1'b0, 2'h3, 3, 32'h0000_1230);
        s_access(1'b0, 2'h1, 1, 32'h0000_0042);
        s_access(1'b0, 2'h2, 1, 32'h0000_0043);
        s_access(1'b1, 2'h0, 2, 32'h0000_0ff0);
        $display("test slave done");
        do_reset(1'b1);
        print_verdict;
    end
endmodule
